// *** design/tach_speed_defines.svh ***
`ifndef TACH_SPEED_DEFINES_SVH
`define TACH_SPEED_DEFINES_SVH
`define ADDR_STOP_DUTY      8'h02
`define ADDR_START_DUTY     8'h03
`define ADDR_MAX_DUTY       8'h05
`define ADDR_START_SPD_HI   8'h06
`define ADDR_START_SPD_LO   8'h07
`define ADDR_SLOPE_HI       8'h08
`define ADDR_SLOPE_LO       8'h09
`define ADDR_CTRL_MODE      8'h0b
`define ADDR_POLE_KEEP      8'h0e
`define ADDR_TACH_RATIO     8'h0f
`define ADDR_PERIOD_HI      8'h1d
`define ADDR_PERIOD_LO      8'h1e
`define REG_RESET           8'h00
`define CLK_HZ              25000000
`define PERIOD_TICK_HZ      250000
`define PERIOD_TICK_DIV     (`CLK_HZ / `PERIOD_TICK_HZ)
`define MAX_DUTY_OFFSET     10'h101
`define SECONDS_PER_MIN     60
`define TACH_RATE_DEN       15
`endif

// *** design/tach_speed_pkg.sv ***
package tach_speed_pkg;
	typedef struct packed {
		logic       wr_en;
		logic       rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;
	typedef struct packed {
		logic       rd_valid;
		logic [7:0] rdata;
	} reg_rsp_s;
	typedef enum logic {LOOP_CLOSED, LOOP_OPEN} loop_e;
endpackage

// *** design/tach_output_and_speed_curve.sv ***
`timescale 1ns/10ps
`include "tach_speed_defines.svh"
// Overview of operation
// - tach pin is open drain: drives low or releases only
// - 16-bit period count in two bytes, frequency is 250000 over count
// - 3-bit ratio field selects pulses per electrical cycle
// - ratio code 111 copies the alert signal onto the tach pin
// - keepalive 0 stops pulses without command, 1 keeps them running
// - 3-bit pole field codes 0..7 mean 2 to 16 poles
// - rpm equals electrical frequency times 60 over pole pairs
// - mode bit 0 is closed loop, 1 is open loop
// - start threshold is start field over 512
// - stop threshold is twice the low 7 bits of stop field over 512
// - max threshold is max field plus 257 over 512
// - 12-bit start speed in rpm from full byte plus upper nibble
// - 14-bit slope at 0.08 rpm per percent per count
// - speed command handled at 9-bit resolution
// - duty command resolution drops at higher input frequency
// - bypass on: command at or above max goes open loop, duty passes
// - bypass ends below max minus (hysteresis plus 1) times 0.4 percent
// - hysteresis nibble sits in low bits of start speed low register
// - bypass enable is bit 1 of slope low register
module tach_output_and_speed_curve
	import tach_speed_pkg::*;
(
	input  wire logic                     CLK_SYS,
	input  wire logic                     RST_B,
	input  wire tach_speed_pkg::reg_req_s REG_REQ,
	output tach_speed_pkg::reg_rsp_s      REG_RSP,
	input  wire logic                     ROTOR_EDGE,
	input  wire logic                     ALERT_IN,
	input  wire logic [8:0]               SPEED_COMMAND_IN,
	input  wire logic                     TACH_OUT_IN,
	output logic                          TACH_OUT_OUT,
	output logic                          TACH_OUT_OE,
	output logic [15:0]                   SPEED_RPM,
	output logic [15:0]                   TARGET_RPM,
	output logic                          LOOP_OPEN_OUT,
	output logic [8:0]                    OPEN_DUTY
);
	import tach_speed_pkg::*;

	logic [7:0]  stop_duty_thr;
	logic [7:0]  start_duty_thr;
	logic [7:0]  max_duty_thr;
	logic [7:0]  start_speed_high;
	logic [7:0]  start_speed_low_and_hysteresis;
	logic [7:0]  speed_slope_high;
	logic [7:0]  speed_slope_low_and_options;
	logic [7:0]  control_mode_select;
	logic [7:0]  pole_and_tach_keepalive;
	logic [7:0]  tach_ratio_select;
	logic [15:0] electrical_period_count;
	logic [15:0] period_run;
	logic [6:0]  tick_div;
	logic        period_tick;
	logic        bypass_active;
	logic [11:0] start_speed;
	logic [13:0] speed_slope;
	logic [3:0]  bypass_hysteresis;
	logic        max_duty_bypass_en;
	logic [2:0]  pole_count_sel;
	logic        tach_keepalive;
	logic [2:0]  tach_ratio_sel;
	logic [9:0]  start_lvl;
	logic [9:0]  stop_lvl;
	logic [9:0]  max_lvl;
	logic [9:0]  exit_lvl;
	logic [9:0]  cmd_lvl;
	logic [3:0]  pole_pairs;
	logic [6:0]  tach_inc;
	logic [26:0] tach_thr;
	logic [26:0] tach_acc;
	logic [26:0] acc_sum;
	logic [26:0] acc_left;
	logic [15:0] period_next;
	logic [31:0] rpm_full;
	logic        tach_level;
	logic        command_present;

	// field extraction
	assign start_speed        = {start_speed_high, start_speed_low_and_hysteresis[7:4]};
	assign bypass_hysteresis  = start_speed_low_and_hysteresis[3:0];
	assign speed_slope        = {speed_slope_high, speed_slope_low_and_options[7:2]};
	assign max_duty_bypass_en = speed_slope_low_and_options[1];
	assign pole_count_sel     = pole_and_tach_keepalive[5:3];
	assign tach_keepalive     = pole_and_tach_keepalive[0];
	assign tach_ratio_sel     = tach_ratio_select[7:5];
	assign pole_pairs         = {1'b0, pole_count_sel} + 4'h1;

	// thresholds on a 512 scale, command taken at 9 bits
	assign start_lvl = {2'b00, start_duty_thr};
	assign stop_lvl  = {2'b00, stop_duty_thr[6:0], 1'b0};
	assign max_lvl   = {2'b00, max_duty_thr} + `MAX_DUTY_OFFSET;
	assign exit_lvl  = max_lvl - {4'h0, ({1'b0, bypass_hysteresis} + 5'h01), 1'b0};
	assign cmd_lvl   = {1'b0, SPEED_COMMAND_IN};
	assign command_present = (cmd_lvl > stop_lvl);

	// register writes
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			stop_duty_thr                  <= `REG_RESET;
			start_duty_thr                 <= `REG_RESET;
			max_duty_thr                   <= `REG_RESET;
			start_speed_high               <= `REG_RESET;
			start_speed_low_and_hysteresis <= `REG_RESET;
			speed_slope_high               <= `REG_RESET;
			speed_slope_low_and_options    <= `REG_RESET;
			control_mode_select            <= `REG_RESET;
			pole_and_tach_keepalive        <= `REG_RESET;
			tach_ratio_select              <= `REG_RESET;
		end else if (REG_REQ.wr_en) begin
			unique case (REG_REQ.addr)
				`ADDR_STOP_DUTY:    stop_duty_thr <= REG_REQ.wdata;
				`ADDR_START_DUTY:   start_duty_thr <= REG_REQ.wdata;
				`ADDR_MAX_DUTY:     max_duty_thr <= REG_REQ.wdata;
				`ADDR_START_SPD_HI: start_speed_high <= REG_REQ.wdata;
				`ADDR_START_SPD_LO: start_speed_low_and_hysteresis <= REG_REQ.wdata;
				`ADDR_SLOPE_HI:     speed_slope_high <= REG_REQ.wdata;
				`ADDR_SLOPE_LO:     speed_slope_low_and_options <= REG_REQ.wdata;
				`ADDR_CTRL_MODE:    control_mode_select <= REG_REQ.wdata;
				`ADDR_POLE_KEEP:    pole_and_tach_keepalive <= REG_REQ.wdata;
				`ADDR_TACH_RATIO:   tach_ratio_select <= REG_REQ.wdata;
				default: ;
			endcase
		end
	end

	// register reads, one cycle latency; unmapped reads return zero
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			REG_RSP <= '0;
		end else begin
			REG_RSP.rd_valid <= REG_REQ.rd_en;
			unique case (REG_REQ.addr)
				`ADDR_STOP_DUTY:    REG_RSP.rdata <= stop_duty_thr;
				`ADDR_START_DUTY:   REG_RSP.rdata <= start_duty_thr;
				`ADDR_MAX_DUTY:     REG_RSP.rdata <= max_duty_thr;
				`ADDR_START_SPD_HI: REG_RSP.rdata <= start_speed_high;
				`ADDR_START_SPD_LO: REG_RSP.rdata <= start_speed_low_and_hysteresis;
				`ADDR_SLOPE_HI:     REG_RSP.rdata <= speed_slope_high;
				`ADDR_SLOPE_LO:     REG_RSP.rdata <= speed_slope_low_and_options;
				`ADDR_CTRL_MODE:    REG_RSP.rdata <= control_mode_select;
				`ADDR_POLE_KEEP:    REG_RSP.rdata <= pole_and_tach_keepalive;
				`ADDR_TACH_RATIO:   REG_RSP.rdata <= tach_ratio_select;
				`ADDR_PERIOD_HI:    REG_RSP.rdata <= electrical_period_count[15:8];
				`ADDR_PERIOD_LO:    REG_RSP.rdata <= electrical_period_count[7:0];
				default:            REG_RSP.rdata <= 8'h00;
			endcase
		end
	end

	// 4 us tick so that frequency is 250000 over the count
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			tick_div    <= 7'h00;
			period_tick <= 1'b0;
		end else begin
			period_tick <= (tick_div == 7'(`PERIOD_TICK_DIV - 1));
			tick_div    <= (tick_div == 7'(`PERIOD_TICK_DIV - 1)) ? 7'h00 : tick_div + 7'h01;
		end
	end

	// a tick landing on the rotor edge belongs to the period it closes, so none is lost
	assign period_next = (period_tick && period_run != 16'hffff) ?
		period_run + 16'h0001 : period_run;

	// period capture on each electrical cycle; saturates on a stalled rotor
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			period_run              <= 16'h0000;
			electrical_period_count <= 16'hffff;
		end else if (ROTOR_EDGE) begin
			electrical_period_count <= period_next;
			period_run              <= 16'h0000;
		end else begin
			period_run <= period_next;
		end
	end

	// rpm = 250000*60/(count*pairs); one divide per cycle, fine for a slow value
	assign rpm_full = (32'(`PERIOD_TICK_HZ) * 32'(`SECONDS_PER_MIN))
		/ (32'(electrical_period_count) * 32'(pole_pairs));
	// a very short period saturates instead of wrapping to a small speed
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			SPEED_RPM <= 16'h0000;
		end else if (electrical_period_count == 16'h0000 || rpm_full > 32'h0000ffff) begin
			SPEED_RPM <= 16'hffff;
		end else begin
			SPEED_RPM <= rpm_full[15:0];
		end
	end

	// bypass state with hysteresis
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			bypass_active <= 1'b0;
		end else if (!max_duty_bypass_en) begin
			bypass_active <= 1'b0;
		end else if (cmd_lvl >= max_lvl) begin
			bypass_active <= 1'b1;
		end else if (cmd_lvl < exit_lvl) begin
			bypass_active <= 1'b0;
		end
	end

	// loop select and speed curve; slope*0.08*(duty%) = slope*dlvl/64
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			LOOP_OPEN_OUT <= 1'b0;
			OPEN_DUTY     <= 9'h000;
			TARGET_RPM    <= 16'h0000;
		end else begin
			LOOP_OPEN_OUT <= control_mode_select[0] || bypass_active;
			OPEN_DUTY     <= SPEED_COMMAND_IN;
			if (cmd_lvl < start_lvl) begin
				TARGET_RPM <= 16'h0000;
			end else if (cmd_lvl >= max_lvl) begin
				TARGET_RPM <= 16'(32'(start_speed) + ((32'(speed_slope) * 32'(max_lvl - start_lvl)) >> 6));
			end else begin
				TARGET_RPM <= 16'(32'(start_speed) + ((32'(speed_slope) * 32'(cmd_lvl - start_lvl)) >> 6));
			end
		end
	end

	// toggles per electrical cycle in fifteenths; two toggles make one pulse
	// fifteenths keep every ratio exact, 2.4 ppr included
	always_comb begin
		unique case (tach_ratio_sel)
			3'b000: tach_inc = 7'd30; // 1 ppr
			3'b001: tach_inc = 7'd20; // 2/3 ppr
			3'b010: tach_inc = 7'd15;
			3'b011: tach_inc = 7'd60;
			3'b100: tach_inc = 7'd90;
			3'b101: tach_inc = 7'd72;
			3'b110: tach_inc = 7'd10;
			3'b111: tach_inc = 7'd0; // alert copy, no rotation pulses
		endcase
	end

	// one electrical cycle spans count*100 clocks, so the threshold scales with the period
	assign tach_thr = 27'(electrical_period_count) * 27'(`PERIOD_TICK_DIV * `TACH_RATE_DEN);
	assign acc_sum  = tach_acc + 27'(tach_inc);
	assign acc_left = acc_sum - tach_thr;

	// no resync on the rotor edge, so fractional ratios keep their phase across cycles;
	// limitation: at most one toggle per clock
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			tach_acc   <= 27'h0000000;
			tach_level <= 1'b1;
		end else if (!(command_present || tach_keepalive)) begin
			tach_acc   <= 27'h0000000;
			tach_level <= 1'b1;
		end else if (acc_sum >= tach_thr) begin
			tach_level <= ~tach_level;
			// after a sudden speed-up the remainder can exceed a whole step; drop it
			tach_acc   <= (acc_left >= tach_thr) ? 27'h0000000 : acc_left;
		end else begin
			tach_acc <= acc_sum;
		end
	end

	// open-drain driver: enable only while pulling low
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			TACH_OUT_OUT <= 1'b0;
			TACH_OUT_OE  <= 1'b0;
		end else begin
			TACH_OUT_OUT <= 1'b0;
			TACH_OUT_OE  <= (tach_ratio_sel == 3'b111) ? ALERT_IN : ~tach_level;
		end
	end

	// checks next to the logic they guard
	a_drain_only: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		TACH_OUT_OUT == 1'b0) else $error("tach pin driven high");
	a_alert_copy: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(tach_ratio_sel == 3'b111) |=> TACH_OUT_OE == $past(ALERT_IN)) else $error("alert not copied");
	a_period_cap: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ROTOR_EDGE |=> electrical_period_count == $past(period_next)) else $error("period not captured");
	a_bypass_on: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(max_duty_bypass_en && cmd_lvl >= max_lvl) |=> ##1 LOOP_OPEN_OUT) else $error("no bypass");
	a_bypass_off: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(cmd_lvl < exit_lvl && cmd_lvl < max_lvl) |=> !bypass_active) else $error("bypass stuck");
	a_mode_open: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		control_mode_select[0] |=> LOOP_OPEN_OUT) else $error("open loop ignored");
	a_keep_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!(command_present || tach_keepalive) |=> tach_level) else $error("tach not stopped");
	a_below_start: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(cmd_lvl < start_lvl) |=> TARGET_RPM == 16'h0000) else $error("target below start");
	a_at_start: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(cmd_lvl == start_lvl) |=> TARGET_RPM == 16'($past(start_speed))) else $error("start speed");
	a_tach_step: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		((command_present || tach_keepalive) && acc_sum >= tach_thr) |=>
		tach_level != $past(tach_level)) else $error("tach step missed");
	a_duty_pass: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		1'b1 |=> OPEN_DUTY == $past(SPEED_COMMAND_IN)) else $error("open duty not passed");
	c_bypass: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $rose(bypass_active));
	c_bypass_exit: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $fell(bypass_active));
	c_tach_toggle: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $fell(tach_level));
	c_alert_mode: cover property (@(posedge CLK_SYS) disable iff (!RST_B) tach_ratio_sel == 3'b111);
endmodule // tach_output_and_speed_curve

// *** tb/tach_host_model.sv ***
`timescale 1ns/10ps
// host side of the tach wire: pull-up plus a pulse counter
module tach_host_model (
	input  wire logic clk_sys,
	input  wire logic oe,
	input  wire logic drv,
	output wire logic pin,
	output int        falls
);
	bit last_pin;
	// released pin floats high through the pull-up, never holds the old level
	assign pin = oe ? drv : 1'b1;
	// one tach pulse counted per falling edge seen on the wire
	always @(posedge clk_sys) begin
		if (last_pin && !pin)
			falls <= falls + 1;
		last_pin <= pin;
	end
endmodule // tach_host_model

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`include "tach_speed_defines.svh"
module testbench;
	import tach_speed_pkg::*;
	logic        clk_sys;
	logic        rst_b;
	reg_req_s    reg_req;
	reg_rsp_s    reg_rsp;
	logic        rotor_edge;
	logic        alert_in;
	logic [8:0]  speed_cmd;
	logic        tach_drv;
	logic        tach_oe;
	wire logic   tach_pin;
	logic [15:0] speed_rpm;
	logic [15:0] target_rpm;
	logic        loop_open;
	logic [8:0]  open_duty;
	int          fail_count;
	int          compares;
	int          base;
	int          falls;
	localparam logic [7:0] RW_ADDR [10] = '{`ADDR_STOP_DUTY, `ADDR_START_DUTY,
		`ADDR_MAX_DUTY, `ADDR_START_SPD_HI, `ADDR_START_SPD_LO, `ADDR_SLOPE_HI,
		`ADDR_SLOPE_LO, `ADDR_CTRL_MODE, `ADDR_POLE_KEEP, `ADDR_TACH_RATIO};

	tach_output_and_speed_curve dut_u (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .REG_REQ(reg_req), .REG_RSP(reg_rsp),
		.ROTOR_EDGE(rotor_edge), .ALERT_IN(alert_in), .SPEED_COMMAND_IN(speed_cmd),
		.TACH_OUT_IN(tach_pin), .TACH_OUT_OUT(tach_drv), .TACH_OUT_OE(tach_oe),
		.SPEED_RPM(speed_rpm), .TARGET_RPM(target_rpm),
		.LOOP_OPEN_OUT(loop_open), .OPEN_DUTY(open_duty)
	);
	tach_host_model host_u (
		.clk_sys(clk_sys), .oe(tach_oe), .drv(tach_drv), .pin(tach_pin), .falls(falls)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle request pulse, then an idle edge before the next call
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys) reg_req <= '0;
	endtask
	// answer stands right after the edge that takes the request, so look 1 ns later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys) reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys) reg_req <= '0;
		#1;
		chk(16'(reg_rsp.rd_valid), 16'h0001);
		chk(16'(reg_rsp.rdata), 16'(exp));
	endtask
	task automatic rotor(input int n, input int gap);
		repeat (n) begin
			@(posedge clk_sys) rotor_edge <= 1'b1;
			@(posedge clk_sys) rotor_edge <= 1'b0;
			repeat (gap) @(posedge clk_sys);
		end
	endtask
	// curve outputs are registered; a few cycles covers the pipeline
	task automatic settle(input logic [8:0] cmd);
		@(posedge clk_sys) speed_cmd <= cmd;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask
	// rotor edges 200 clocks apart give a period of two ticks; priming lets it settle,
	// then the window spans whole pulse periods so the count of falls is exact
	task automatic tach_run(input logic [7:0] code, input int cyc, input int exp);
		wr(`ADDR_TACH_RATIO, code << 5);
		rotor(3, 198);
		base = falls;
		rotor(cyc, 198);
		chk(16'(falls - base), 16'(exp));
	endtask
	task automatic final_report;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// watchdog: the sequence needs roughly 33000 cycles
	initial begin
		repeat (80000) @(posedge clk_sys);
		fail_count++;
		final_report;
	end
	// main sequence
	initial begin
		rst_b = 1'b0;
		reg_req = '0;
		rotor_edge = 1'b0;
		alert_in = 1'b0;
		speed_cmd = 9'h000;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		foreach (RW_ADDR[i]) rd(RW_ADDR[i], `REG_RESET);
		rd(`ADDR_PERIOD_HI, 8'hff);
		rd(8'h10, 8'h00);
		wr(`ADDR_PERIOD_HI, 8'h12);
		rd(`ADDR_PERIOD_HI, 8'hff);
		foreach (RW_ADDR[i]) wr(RW_ADDR[i], RW_ADDR[i] ^ 8'h5a);
		foreach (RW_ADDR[i]) rd(RW_ADDR[i], RW_ADDR[i] ^ 8'h5a);
		wr(`ADDR_STOP_DUTY, 8'h00);
		wr(`ADDR_POLE_KEEP, 8'h01);
		tach_run(8'h0, 6, 6);
		tach_run(8'h3, 6, 12);
		tach_run(8'h4, 6, 18);
		tach_run(8'h2, 6, 3);
		tach_run(8'h5, 5, 12);
		tach_run(8'h1, 6, 4);
		tach_run(8'h6, 6, 2);
		wr(`ADDR_POLE_KEEP, 8'h00);
		tach_run(8'h3, 6, 0);
		wr(`ADDR_STOP_DUTY, 8'h32);
		settle(9'd100);
		tach_run(8'h3, 6, 0);
		settle(9'd101);
		tach_run(8'h3, 6, 12);
		wr(`ADDR_TACH_RATIO, 8'he0);
		@(posedge clk_sys) alert_in <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		chk(16'(tach_oe), 16'h0001);
		chk(16'({tach_pin, tach_drv}), 16'h0000);
		@(posedge clk_sys) alert_in <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk(16'({tach_oe, tach_pin}), 16'h0001);
		wr(`ADDR_POLE_KEEP, 8'h38);
		rotor(3, 4998);
		rd(`ADDR_PERIOD_HI, 8'h00);
		rd(`ADDR_PERIOD_LO, 8'h32);
		chk(speed_rpm, 16'(15000000 / (50 * 8)));
		wr(`ADDR_START_DUTY, 8'h66);
		wr(`ADDR_MAX_DUTY, 8'hcc);
		wr(`ADDR_START_SPD_HI, 8'h5d);
		wr(`ADDR_START_SPD_LO, 8'hc9);
		wr(`ADDR_SLOPE_HI, 8'h25);
		wr(`ADDR_SLOPE_LO, 8'h9c);
		wr(`ADDR_CTRL_MODE, 8'h00);
		settle(9'd300);
		chk(target_rpm, 16'(1500 + 2407 * 198 / 64));
		chk(16'(loop_open), 16'h0000);
		settle(9'd480);
		chk(target_rpm, 16'(1500 + 2407 * 359 / 64));
		chk(16'(loop_open), 16'h0000);
		settle(9'd50);
		chk(target_rpm, 16'h0000);
		wr(`ADDR_SLOPE_LO, 8'h9e);
		settle(9'd460);
		chk(16'(loop_open), 16'h0000);
		settle(9'd461);
		chk(16'({loop_open, open_duty}), 16'h03cd);
		settle(9'd441);
		chk(16'(loop_open), 16'h0001);
		settle(9'd440);
		chk(16'(loop_open), 16'h0000);
		wr(`ADDR_CTRL_MODE, 8'h01);
		settle(9'd200);
		chk(16'({loop_open, open_duty}), 16'h02c8);
		final_report;
	end
endmodule // testbench
